// ### shared/spkd_map.svh
`ifndef SPKD_MAP_SVH
`define SPKD_MAP_SVH

// register byte offsets
`define SPKD_OFF_CTRL1      8'h00
`define SPKD_OFF_CTRL2      8'h04
`define SPKD_OFF_STATUS     8'h08
`define SPKD_OFF_DIAG0      8'h10
`define SPKD_OFF_DIAG3      8'h1C

// control_byte_one fields
`define SPKD_C1_STBY_OUT    0
`define SPKD_C1_DIAG_EN     1
`define SPKD_C1_OFFSET_EN   5

// control_byte_two fields
`define SPKD_C2_GAIN_LOW    0
`define SPKD_C2_LINE_DIAG   1
`define SPKD_C2_AC_EN       2
`define SPKD_C2_AC_THR_LOW  7

// reset values
`define SPKD_CTRL1_RST      8'h00
`define SPKD_CTRL2_RST      8'h00

// timing: clock rate and times in microseconds
`define SPKD_CLK_MHZ        125
`define SPKD_T_RECHECK_US   1000
`define SPKD_T_DIAG_US      100000
`define SPKD_T_TURNON_US    100000

// tweeter confirmation pulse count
`define SPKD_AC_PULSES      2'h3

`endif

// ### shared/spkd_pkg.sv
package spkd_pkg;

   // one channel_diag_byte as seen by software
   typedef struct packed {
      logic rsvd;
      logic perm_fault;
      logic open_tweeter;
      logic offset_excess;
      logic open_load;
      logic shorted_load;
      logic short_vs;
      logic short_gnd;
   } spkd_diag_t;

   // analog sense flags of one channel
   typedef struct packed {
      logic overload;
      logic ac_pulse;
      logic offset_hi;
      logic open_load;
      logic shorted_load;
      logic short_vs;
      logic short_gnd;
   } spkd_sense_t;

   typedef enum logic [1:0] {
      TOP_STBY,
      TOP_PULSE,
      TOP_PLAY
   } spkd_top_t;

   typedef enum logic [1:0] {
      CH_ACTIVE,
      CH_CHECK,
      CH_DIAG,
      CH_RESTART
   } spkd_ch_t;

endpackage : spkd_pkg

// ### design/spkd_diag_core.sv
// Overview of operation
// - turn-on pulse classifies shorts and open load
// - turn-on result held until read or diag cycle; read rearms
// - combined wake plus diag: pulse first, unbiased
// - after bias, permanent diagnosis overwrites turn-on result
// - capture at pulse end, 100 ms acquisition
// - short thresholds independent of gain
// - low gain plus line option: line thresholds
// - permanent: shorts only, no offset or open load
// - restart mode: faulty channel off, 1 ms recheck
// - diagnostic mode by bus or overload
// - recheck after 1 ms, else 100 ms cycle
// - after cycle restart, store, wait read
// - flag output offset beyond 2 V
// - offset window from last read or enable
// - offset reported only if whole window
// - protection suppresses offset and AC tests
// - AC diagnosis enabled by control two bit 2
// - control two bit 7 picks AC threshold
// - three pulses confirm tweeter, else open
// - read returns previous cycle, rearms next
//
// The address map and the APB register port were chosen for this implementation.
`include "spkd_map.svh"

module spkd_diag_core
   import spkd_pkg::*;
#(
   parameter int RECHECK_CYC = `SPKD_T_RECHECK_US * `SPKD_CLK_MHZ,
   parameter int DIAG_CYC    = `SPKD_T_DIAG_US * `SPKD_CLK_MHZ,
   parameter int TURNON_CYC  = `SPKD_T_TURNON_US * `SPKD_CLK_MHZ
)(
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire spkd_sense_t [3:0] sense,
   output logic                   test_pulse_on,
   output logic                   stage_biased,
   output logic [3:0]             ch_enable,
   output logic                   load_thr_line,
   output logic                   ac_thr_low
);

   logic             rst_meta_reg;
   logic             rst_n_reg;
   logic             pready_reg;
   logic [31:0]      prdata_reg;
   logic             pslverr_reg;
   logic [7:0]       ctrl1_reg;
   logic [7:0]       ctrl2_reg;
   spkd_top_t        top_reg;
   logic [23:0]      top_cnt_reg;
   logic             pulse_armed_reg;
   logic             test_pulse_reg;
   logic             biased_reg;
   logic             line_thr_reg;
   logic             ac_low_reg;
   logic [3:0]       ch_en_reg;
   logic [3:0]       perm_armed_reg;
   logic [3:0]       perm_done;
   spkd_diag_t [3:0] perm_meas;
   spkd_diag_t [3:0] meas_reg;
   spkd_diag_t [3:0] shown_reg;
   logic [3:0]       ofs_hold_reg;
   logic             ofs_open_reg;
   logic [1:0]       ac_cnt_reg [4];
   logic [3:0]       ac_prev_reg;
   logic [3:0]       ac_void_reg;
   logic             bus_acc;
   logic             wr_hit;
   logic             rd_diag;
   logic             addr_ok;
   logic             combined_wake;

   assign pready        = pready_reg;
   assign prdata        = prdata_reg;
   assign pslverr       = pslverr_reg;
   assign test_pulse_on = test_pulse_reg;
   assign stage_biased  = biased_reg;
   assign ch_enable     = ch_en_reg;
   assign load_thr_line = line_thr_reg;
   assign ac_thr_low    = ac_low_reg;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // bus decode; one wait state per access
   assign bus_acc = psel && penable && pready_reg;
   assign addr_ok = (paddr == `SPKD_OFF_CTRL1) || (paddr == `SPKD_OFF_CTRL2) ||
                    (paddr == `SPKD_OFF_STATUS) ||
                    ((paddr >= `SPKD_OFF_DIAG0) && (paddr <= `SPKD_OFF_DIAG3) && (paddr[1:0] == 2'h0));
   assign wr_hit  = bus_acc && pwrite && addr_ok;
   assign rd_diag = bus_acc && !pwrite && (paddr >= `SPKD_OFF_DIAG0) && (paddr <= `SPKD_OFF_DIAG3) &&
                    (paddr[1:0] == 2'h0);
   assign combined_wake = wr_hit && (paddr == `SPKD_OFF_CTRL1) && pwdata[`SPKD_C1_STBY_OUT] &&
                          pwdata[`SPKD_C1_DIAG_EN];

   // ready, read data and error answer
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg  <= psel && penable && !pready_reg;
         pslverr_reg <= psel && penable && !pready_reg && !addr_ok;
         prdata_reg  <= 32'h0000_0000;
         if (psel && penable && !pready_reg && !pwrite)
         begin
            if (paddr == `SPKD_OFF_CTRL1)
               prdata_reg <= {24'h00_0000, ctrl1_reg};
            else if (paddr == `SPKD_OFF_CTRL2)
               prdata_reg <= {24'h00_0000, ctrl2_reg};
            else if (paddr == `SPKD_OFF_STATUS)
               prdata_reg <= {20'h0_0000, ch_en_reg, 2'h0, biased_reg, test_pulse_reg, 2'h0, top_reg};
            else if (addr_ok)
               prdata_reg <= {24'h00_0000, shown_reg[paddr[3:2]]}; // previous cycle
         end
      end
   end

   // control bytes
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         ctrl1_reg <= `SPKD_CTRL1_RST;
         ctrl2_reg <= `SPKD_CTRL2_RST;
      end
      else if (wr_hit && paddr == `SPKD_OFF_CTRL1)
         ctrl1_reg <= pwdata[7:0];
      else if (wr_hit && paddr == `SPKD_OFF_CTRL2)
         ctrl2_reg <= pwdata[7:0];
   end

   // threshold selects; short thresholds take no gain input
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         line_thr_reg <= 1'b0;
         ac_low_reg   <= 1'b0;
      end
      else
      begin
         line_thr_reg <= ctrl2_reg[`SPKD_C2_GAIN_LOW] && ctrl2_reg[`SPKD_C2_LINE_DIAG];
         ac_low_reg   <= ctrl2_reg[`SPKD_C2_AC_THR_LOW];
      end
   end

   // turn-on sequencer: standby, test pulse, biased play
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         top_reg        <= TOP_STBY;
         top_cnt_reg    <= 24'h00_0000;
         test_pulse_reg <= 1'b0;
         biased_reg     <= 1'b0;
      end
      else
      begin
         case (top_reg)
            TOP_STBY:
            begin
               if (combined_wake && pulse_armed_reg)
               begin
                  top_reg        <= TOP_PULSE; // stage stays off
                  test_pulse_reg <= 1'b1;
                  top_cnt_reg    <= 24'h00_0000;
               end
               else if (ctrl1_reg[`SPKD_C1_STBY_OUT])
               begin
                  top_reg    <= TOP_PLAY;
                  biased_reg <= 1'b1;
               end
            end
            TOP_PULSE:
            begin
               top_cnt_reg <= top_cnt_reg + 24'h00_0001;
               if (top_cnt_reg == 24'(TURNON_CYC - 1))
               begin
                  test_pulse_reg <= 1'b0;
                  biased_reg     <= 1'b1; // bias only after pulse
                  top_reg        <= TOP_PLAY;
               end
            end
            TOP_PLAY:
            begin
               if (!ctrl1_reg[`SPKD_C1_STBY_OUT])
               begin
                  top_reg    <= TOP_STBY;
                  biased_reg <= 1'b0;
               end
            end
            default:
               top_reg <= TOP_STBY;
         endcase
      end
   end

   // turn-on pulse armed again only by a result read
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         pulse_armed_reg <= 1'b1;
      else if (top_reg == TOP_PULSE && top_cnt_reg == 24'(TURNON_CYC - 1))
         pulse_armed_reg <= 1'b0;
      else if (rd_diag)
         pulse_armed_reg <= 1'b1;
   end

   // per-channel permanent diagnosis and restart
   for (genvar c = 0; c < 4; c++)
   begin : g_ch
      spkd_ch_t    st_reg;
      logic [23:0] cnt_reg;

      always_ff @(posedge core_clk or negedge rst_n_reg)
      begin
         if (!rst_n_reg)
         begin
            st_reg       <= CH_ACTIVE;
            cnt_reg      <= 24'h00_0000;
            ch_en_reg[c] <= 1'b0;
         end
         else if (!biased_reg)
         begin
            st_reg       <= CH_ACTIVE;
            cnt_reg      <= 24'h00_0000;
            ch_en_reg[c] <= 1'b0;
         end
         else
         begin
            cnt_reg <= cnt_reg + 24'h00_0001;
            case (st_reg)
               CH_ACTIVE:
               begin
                  ch_en_reg[c] <= !sense[c].overload;
                  cnt_reg      <= 24'h00_0000;
                  if (sense[c].overload && ctrl1_reg[`SPKD_C1_DIAG_EN])
                     st_reg <= CH_CHECK; // self activation
                  else if (sense[c].overload)
                     st_reg <= CH_RESTART; // only this channel off
               end
               CH_CHECK:
               begin
                  if (cnt_reg == 24'(RECHECK_CYC - 1))
                  begin
                     cnt_reg <= 24'h00_0000;
                     if (!sense[c].overload)
                        st_reg <= CH_ACTIVE;
                     else if (perm_armed_reg[c])
                        st_reg <= CH_DIAG;
                     else
                        st_reg <= CH_RESTART;
                  end
               end
               CH_DIAG:
               begin
                  if (cnt_reg == 24'(DIAG_CYC - 1))
                  begin
                     cnt_reg <= 24'h00_0000;
                     st_reg  <= CH_RESTART;
                  end
               end
               CH_RESTART:
               begin
                  if (cnt_reg == 24'(RECHECK_CYC - 1)) // 1 ms status poll
                  begin
                     cnt_reg <= 24'h00_0000;
                     if (!sense[c].overload)
                        st_reg <= CH_ACTIVE;
                  end
               end
               default:
                  st_reg <= CH_ACTIVE;
            endcase
         end
      end

      // diag cycle result: shorts only, open load not seen
      assign perm_done[c] = biased_reg && st_reg == CH_DIAG && cnt_reg == 24'(DIAG_CYC - 1);
      always_comb
      begin
         perm_meas[c]              = '0;
         perm_meas[c].short_gnd    = sense[c].short_gnd;
         perm_meas[c].short_vs     = !sense[c].short_gnd && sense[c].short_vs;
         perm_meas[c].shorted_load = !sense[c].short_gnd && !sense[c].short_vs;
         perm_meas[c].perm_fault   = 1'b1;
      end

      always_ff @(posedge core_clk or negedge rst_n_reg)
      begin
         if (!rst_n_reg)
            perm_armed_reg[c] <= 1'b1;
         else if (rd_diag)
            perm_armed_reg[c] <= 1'b1; // next cycle after read
         else if (perm_done[c])
            perm_armed_reg[c] <= 1'b0;
      end

      chk_check_wait_exact: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
         (biased_reg && st_reg == CH_CHECK && cnt_reg < 24'(RECHECK_CYC - 1)) |=> st_reg == CH_CHECK)
         else $error("channel left recheck before 1 ms");
      chk_restart_off: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
         (biased_reg && st_reg == CH_RESTART) |=> !ch_en_reg[c])
         else $error("faulty channel driven during restart");
      chk_overload_route: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
         (biased_reg && st_reg == CH_ACTIVE && sense[c].overload && ctrl1_reg[`SPKD_C1_DIAG_EN])
         |=> st_reg == CH_CHECK)
         else $error("overload did not start diagnostic mode");
   end

   // measured results; one write per channel per cycle
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         meas_reg  <= '0;
         shown_reg <= '0;
      end
      else
      begin
         for (int c = 0; c < 4; c++)
         begin
            if (rd_diag)
            begin
               shown_reg[c] <= meas_reg[c];
               meas_reg[c]  <= '0;
               meas_reg[c].offset_excess <= ofs_open_reg && ofs_hold_reg[c] && !ac_void_reg[c];
               meas_reg[c].open_tweeter  <= ctrl2_reg[`SPKD_C2_AC_EN] && !ac_void_reg[c] &&
                                            (ac_cnt_reg[c] < `SPKD_AC_PULSES);
            end
            else if (top_reg == TOP_PULSE && top_cnt_reg == 24'(TURNON_CYC - 1))
            begin
               meas_reg[c].short_gnd    <= sense[c].short_gnd;
               meas_reg[c].short_vs     <= !sense[c].short_gnd && sense[c].short_vs;
               meas_reg[c].shorted_load <= !sense[c].short_gnd && !sense[c].short_vs && sense[c].shorted_load;
               meas_reg[c].open_load    <= !sense[c].short_gnd && !sense[c].short_vs &&
                                           !sense[c].shorted_load && sense[c].open_load;
            end
            else if (perm_done[c])
               meas_reg[c] <= perm_meas[c]; // turn-on result replaced only by a short
         end
      end
   end

   // offset window and AC pulse counting
   always_ff @(posedge core_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         ofs_open_reg <= 1'b0;
         ofs_hold_reg <= 4'h0;
         ac_prev_reg  <= 4'h0;
         ac_void_reg  <= 4'h0;
         for (int c = 0; c < 4; c++)
            ac_cnt_reg[c] <= 2'h0;
      end
      else
      begin
         for (int c = 0; c < 4; c++)
         begin
            ac_prev_reg[c] <= sense[c].ac_pulse;
            if (rd_diag || !ctrl2_reg[`SPKD_C2_AC_EN])
            begin
               ac_cnt_reg[c]  <= 2'h0; // new period per read or enable
               ac_void_reg[c] <= 1'b0;
            end
            else
            begin
               if (sense[c].overload)
                  ac_void_reg[c] <= 1'b1;
               if (sense[c].ac_pulse && !ac_prev_reg[c] && ac_cnt_reg[c] != `SPKD_AC_PULSES)
                  ac_cnt_reg[c] <= ac_cnt_reg[c] + 2'h1;
            end
            if (rd_diag || (wr_hit && paddr == `SPKD_OFF_CTRL1 && pwdata[`SPKD_C1_OFFSET_EN] &&
                            !ctrl1_reg[`SPKD_C1_OFFSET_EN]))
               ofs_hold_reg[c] <= 1'b1; // window start
            else if (!sense[c].offset_hi || sense[c].overload)
               ofs_hold_reg[c] <= 1'b0; // must persist, protection cancels
         end
         ofs_open_reg <= ctrl1_reg[`SPKD_C1_OFFSET_EN] ||
                         (wr_hit && paddr == `SPKD_OFF_CTRL1 && pwdata[`SPKD_C1_OFFSET_EN]);
      end
   end

   // sequences for the turn-on path
   sequence s_pulse_start;
      top_reg == TOP_STBY && combined_wake && pulse_armed_reg;
   endsequence
   sequence s_pulse_running;
      test_pulse_reg && !biased_reg && top_reg == TOP_PULSE;
   endsequence

   chk_pulse_before_bias: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      s_pulse_start |=> s_pulse_running [*2])
      else $error("bias applied during turn-on pulse");
   chk_pulse_end_bias: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      (top_reg == TOP_PULSE && top_cnt_reg == 24'(TURNON_CYC - 1)) |=> (biased_reg && !test_pulse_reg))
      else $error("pulse did not end into biased play");
   chk_pulse_rearm: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      (top_reg == TOP_PULSE && top_cnt_reg == 24'(TURNON_CYC - 1)) |=> !pulse_armed_reg)
      else $error("turn-on pulse still armed without read");
   chk_read_shift: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      rd_diag |=> shown_reg == $past(meas_reg))
      else $error("read did not present previous cycle");
   chk_line_thr: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      ##1 line_thr_reg == $past(ctrl2_reg[`SPKD_C2_GAIN_LOW] && ctrl2_reg[`SPKD_C2_LINE_DIAG]))
      else $error("line driver threshold select wrong");
   chk_ac_void: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      (ctrl2_reg[`SPKD_C2_AC_EN] && !rd_diag && sense[0].overload) |=> ac_void_reg[0])
      else $error("protection did not suppress AC test");
   chk_ofs_persist: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      (!rd_diag && !wr_hit && !sense[0].offset_hi) |=> !ofs_hold_reg[0])
      else $error("offset kept after condition dropped");
   chk_ac_thr: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
      ##1 ac_low_reg == $past(ctrl2_reg[`SPKD_C2_AC_THR_LOW]))
      else $error("AC threshold select wrong");

endmodule : spkd_diag_core

// ### verification/spkd_host_model.sv
module spkd_host_model
   import spkd_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // bus idle from time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
   end

   // one transfer: setup, access held until ready, then release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // look at ready between edges, so the edge that follows is the taking edge
      // only the bench watchdog ends a wait on a dead slave
      @(negedge core_clk);
      while (pready !== 1'b1)
         @(negedge core_clk);
      q = prdata;
      e = pslverr;
      @(posedge core_clk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : spkd_host_model

// ### verification/spkd_diag_core_test.sv
`include "spkd_map.svh"

module spkd_diag_core_test
   import spkd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int RCK = 8;
   localparam int DCY = 20;
   localparam int TCY = 20;

   logic              core_clk = 1'b0;
   logic              arst_n   = 1'b0;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic              pready;
   logic              pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   spkd_sense_t [3:0] sense    = '0;
   logic              test_pulse_on;
   logic              stage_biased;
   logic              load_thr_line;
   logic              ac_thr_low;
   logic [3:0]        ch_enable;
   logic [31:0]       q;
   logic              e;
   logic [7:0]        c2v [4]  = '{8'h01, 8'h03, 8'h02, 8'h80};
   int                n_errors = 0;
   int                comparisons = 0;

   // 125 MHz core clock
   always #4 core_clk = ~core_clk;

   spkd_diag_core #(.RECHECK_CYC(RCK), .DIAG_CYC(DCY), .TURNON_CYC(TCY)) i_spkd_diag_core (
      .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .sense(sense), .test_pulse_on(test_pulse_on), .stage_biased(stage_biased),
      .ch_enable(ch_enable), .load_thr_line(load_thr_line), .ac_thr_low(ac_thr_low));

   spkd_host_model i_spkd_host_model (
      .core_clk(core_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   // compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_spkd_host_model.xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      i_spkd_host_model.xfer(1'b0, a, 32'h0, q, e);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   // bounded wait for one channel enable to reach a level
   task automatic wait_en(input int b, input logic v, input int n);
      for (int k = 0; k < n && ch_enable[b] !== v; k++) @(posedge core_clk);
   endtask : wait_en

   // one window on channel 0: tone pulses, optional offset dip, closed by a read
   task automatic win(input int np, input logic dip);
      repeat (np)
      begin
         @(posedge core_clk) sense[0].ac_pulse <= 1'b1;
         @(posedge core_clk) sense[0].ac_pulse <= 1'b0;
      end
      if (dip)
      begin
         @(posedge core_clk) sense[0].offset_hi <= 1'b0;
         @(posedge core_clk) sense[0].offset_hi <= 1'b1;
      end
      rd(`SPKD_OFF_DIAG0);
   endtask : win

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run

   // watchdog far beyond the expected run length
   initial
   begin
      cyc(20000);
      n_errors++;
      $display("[ERR] watchdog expected done seen hang");
      complete_run();
   end

   initial
   begin
      cyc(10);
      arst_n <= 1'b1;
      cyc(3);
      rd(`SPKD_OFF_CTRL1);
      chk("ctrl1 reset", 32'h0, q);
      rd(8'h0C);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
      $display("test reset done");
      // combined wake and diagnosis with a grounded output
      sense[0].short_gnd <= 1'b1;
      wr(`SPKD_OFF_CTRL1, 32'h03);
      cyc(2);
      chk("pulse on", 32'h1, {31'h0, test_pulse_on});
      chk("biased in pulse", 32'h0, {31'h0, stage_biased});
      for (int k = 0; k < TCY + 40 && stage_biased !== 1'b1; k++) @(posedge core_clk);
      chk("pulse off", 32'h0, {31'h0, test_pulse_on});
      sense[0].short_gnd <= 1'b0;
      rd(`SPKD_OFF_DIAG0);
      chk("diag first read", 32'h00, q);
      rd(`SPKD_OFF_DIAG0);
      chk("diag second read", 32'h01, q);
      rd(`SPKD_OFF_DIAG0);
      chk("diag after clear", 32'h00, q);
      rd(`SPKD_OFF_STATUS);
      chk("status play", 32'h0F22, q);
      $display("test turn-on done");
      // gain and threshold selections
      for (int k = 0; k < 4; k++)
      begin
         wr(`SPKD_OFF_CTRL2, {24'h0, c2v[k]});
         rd(`SPKD_OFF_CTRL2);
         chk("ctrl2 readback", {24'h0, c2v[k]}, q);
         chk("line thr", {31'h0, c2v[k] == 8'h03}, {31'h0, load_thr_line});
         chk("ac thr", {31'h0, c2v[k][7]}, {31'h0, ac_thr_low});
      end
      $display("test thresholds done");
      // tone test and offset window, input otherwise quiet
      wr(`SPKD_OFF_CTRL2, 32'h04);
      sense[0].offset_hi <= 1'b1;
      wr(`SPKD_OFF_CTRL1, 32'h23);
      repeat (3) win(2, 1'b0);
      chk("two pulses", 32'h30, q);
      repeat (3) win(3, 1'b1);
      chk("three pulses", 32'h00, q);
      sense[0].offset_hi <= 1'b0;
      wr(`SPKD_OFF_CTRL2, 32'h00);
      $display("test ac offset done");
      // restart mode, diagnosis off
      wr(`SPKD_OFF_CTRL1, 32'h01);
      sense[3].overload <= 1'b1;
      wait_en(3, 1'b0, RCK + 4);
      chk("restart off", 32'h7, {28'h0, ch_enable});
      sense[3].overload <= 1'b0;
      wait_en(3, 1'b1, 2 * RCK + 4);
      chk("restart back", 32'hF, {28'h0, ch_enable});
      $display("test restart done");
      // diagnostic mode: a spike clears, a lasting short runs a cycle
      wr(`SPKD_OFF_CTRL1, 32'h03);
      sense[1].overload <= 1'b1;
      cyc(2);
      sense[1].overload <= 1'b0;
      cyc(RCK + 4);
      chk("recheck clear", 32'hF, {28'h0, ch_enable});
      sense[2].overload <= 1'b1;
      sense[2].short_vs <= 1'b1;
      wait_en(2, 1'b0, RCK + DCY + 10);
      cyc(RCK + DCY + 8);
      chk("diag restart", 32'hB, {28'h0, ch_enable});
      rd(`SPKD_OFF_DIAG0 + 8'h08);
      rd(`SPKD_OFF_DIAG0 + 8'h08);
      chk("perm result", 32'h42, q & 32'h42);
      $display("test diagnostic mode done");
      complete_run();
   end
endmodule : spkd_diag_core_test
